//--- tfm_pkg.sv
// tfm_pkg: constants shared by the fault monitor files.
// assumes a 32-bit readout word and a 12-bit control/status port.
package tfm_pkg;
    // register indices on the 12-bit control/status port
    localparam logic [4:0]  IDX_FAULT_ENABLE = 5'h0C;
    localparam logic [4:0]  IDX_FAULT_STATUS = 5'h10;
    localparam logic [11:0] MASK_RESET       = 12'h000;
    localparam int          HARD_W           = 9;
    localparam int          TRANS_W          = 7;
    // hard fault bit positions
    localparam int HB_COARSE  = 0;
    localparam int HB_CHSEL   = 1;
    localparam int HB_L1      = 2;
    localparam int HB_TRIG    = 3;
    localparam int HB_MATCHSM = 4;
    localparam int HB_ROFIFO  = 5;
    localparam int HB_ROSM    = 6;
    localparam int HB_CTRL    = 7;
    localparam int HB_INSTR   = 8;
    // transient bit positions
    localparam int TB_L1_OVF  = 0;
    localparam int TB_TRG_OVF = 1;
    localparam int TB_RO_OVF  = 2;
    localparam int TB_HIT     = 3;
    localparam int TB_L1_OVF2 = 5;
    localparam int TB_CHB_OVF = 6;
    // memory parity sources and widths
    localparam int MEM_N      = 4;
    localparam int MEM_W      = 16;
    localparam int CHAN_N     = 24;
    localparam int SM_W       = 8;
    // packet fields
    localparam logic [3:0] PKT_FAULT  = 4'h6;
    localparam logic [3:0] PKT_DEBUG  = 4'h7;
    localparam logic [3:0] SUB_SEP    = 4'h0;
    localparam logic [3:0] SUB_OCC    = 4'h1;
    localparam int         OCC_FULL_B = 8;
    localparam int         WORD_W     = 32;
    localparam int         BUF_DEPTH  = 2;
endpackage : tfm_pkg

//--- tfm_word_if.sv
// tfm_word_if: valid/ready word channel between monitor and buffer.
// assumes both ends on the core clock.
`timescale 1ns/1ps
interface tfm_word_if;
    logic        valid;
    logic        ready;
    logic [31:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : tfm_word_if

//--- tfm_parity_check.sv
// tfm_parity_check: even parity check of memory words on use.
// assumes parity bit equals the xor of the stored data bits.
`timescale 1ns/1ps
module tfm_parity_check (
    input  wire logic [tfm_pkg::MEM_N*tfm_pkg::MEM_W-1:0] i_data,
    input  wire logic [tfm_pkg::MEM_N-1:0]                i_par,
    input  wire logic [tfm_pkg::MEM_N-1:0]                i_use,
    output logic      [tfm_pkg::MEM_N-1:0]                o_err
);
    // one checker per memory read port
    for (genvar g = 0; g < tfm_pkg::MEM_N; g++) begin : g_chk
        assign o_err[g] = i_use[g] &
            ((^i_data[g*tfm_pkg::MEM_W +: tfm_pkg::MEM_W]) != i_par[g]);
    end
endmodule : tfm_parity_check

//--- tfm_out_buffer.sv
// tfm_out_buffer: two-entry word buffer ahead of the readout path.
// assumes the reader may stall freely; no word is dropped.
`timescale 1ns/1ps
module tfm_out_buffer (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    tfm_word_if.sink         up,
    output logic             o_valid,
    output logic [31:0]      o_data,
    input  wire logic        i_ready
);
    typedef struct packed {
        logic [1:0][31:0] mem;
        logic             wp;
        logic             rp;
        logic [1:0]       cnt;
    } tfm_buf_type;

    tfm_buf_type r, n;
    logic push, pop;

    assign up.ready = (r.cnt != 2'h2);
    assign o_valid  = (r.cnt != 2'h0);
    assign o_data   = r.mem[r.rp];
    assign push     = up.valid & up.ready;
    assign pop      = o_valid & i_ready;

    // pointer and count update; push and pop may share a cycle
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = up.data;
            n.wp        = ~r.wp;
        end
        if (pop) begin
            n.rp = ~r.rp;
        end
        n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : tfm_out_buffer

//--- tfm_top.sv
// tfm_top: hard/transient fault supervision and debug word output.
// assumes requests are held until O_REQ_READY; all on I_CORE_CLK.
// What this block does
// - separator word: 0111, chip id, subtype 0000, trigger time tag.
// - occupancy word: 0111, subtype 0001, readout full flag, fill count.
// - nine hard faults each have an enable bit and readable status bit.
// - transient faults never latch in status; reported only in the stream.
// - a fault word holds either hard or transient flags, never both.
// - memories carry parity, checked on use; mismatch raises hard fault.
// - state machines are one-hot and checked every cycle for illegal states.
// - instruction register parity error raises a dedicated hard fault.
// - control register parity error raises a dedicated hard fault.
// - a detected hard fault sets its status bit until a clearing event.
// - status clears on reset, fault-clear, marking, or counter resets when clear-on-counter-reset is set.
// - global fault is the OR of status bits each gated by its mask.
// - marking off: no action; on: events after a fault get a flag.
// - hard bits: coarse,chsel,L1,trig,match sm,ro fifo,ro sm,ctrl,instr.
// - channel select fault when more than one channel is selected.
// - active transient bits depend on the trigger-matching enable.
// - matching on: L1 ovf, trig lost, ro ovf, hit fault at 0..3; 4 zero.
// - matching off: gated L1 overflow at 5, channel buffer overflow at 6.
// - readout overflow: rofull reject and full, with rejection condition.
// - hit fault bit set when corrupted hit data reaches matching.
// - fault word only if a fault occurred, before the trailer.
// - fault word: type 0110, chip id, flags in the low bits.
`timescale 1ns/1ps
module tfm_top (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_NRST,
    // control/status register port
    input  wire logic        I_CSR_WR,
    input  wire logic [4:0]  I_CSR_ADDR,
    input  wire logic [11:0] I_CSR_WDATA,
    output logic      [11:0] O_CSR_RDATA,
    // control bits held elsewhere in the control registers
    input  wire logic [3:0]  I_CHIP_IDENTIFIER,
    input  wire logic        I_FAULT_CLEAR,
    input  wire logic        I_CLR_ON_CNT_RST,
    input  wire logic        I_BUNCH_CNT_RST,
    input  wire logic        I_EVENT_CNT_RST,
    input  wire logic        I_EVENT_MARK_EN,
    input  wire logic        I_MATCH_EN,
    input  wire logic        I_MARK_OVR_EN,
    input  wire logic        I_ROFULL_REJECT,
    input  wire logic        I_LEVEL1_FULL_REJECTION,
    input  wire logic        I_TRFULL_REJECT,
    // hard fault sources
    input  wire logic [63:0] I_MEM_DATA,
    input  wire logic [3:0]  I_MEM_PAR,
    input  wire logic [3:0]  I_MEM_USE,
    input  wire logic [23:0] I_CHAN_SEL,
    input  wire logic [7:0]  I_MATCH_STATE,
    input  wire logic [7:0]  I_RO_STATE,
    input  wire logic [3:0]  I_INSTR,
    input  wire logic        I_INSTR_PAR,
    // transient fault sources
    input  wire logic        I_L1_OVERFLOW,
    input  wire logic        I_TRIG_LOST,
    input  wire logic        I_RO_FIFO_FULL,
    input  wire logic        I_L1_NEARLY_FULL,
    input  wire logic        I_TRIG_NEARLY_FULL,
    input  wire logic        I_HIT_ERR_IN,
    input  wire logic        I_CHBUF_REJECTED,
    // word requests
    input  wire logic        I_FAULT_SLOT,
    input  wire logic        I_SEP_REQ,
    input  wire logic [11:0] I_TRIGGER_TIME_TAG,
    input  wire logic        I_OCC_REQ,
    input  wire logic [7:0]  I_LEVEL1_FILL_COUNT,
    output logic             O_REQ_READY,
    // readout word path
    output logic             O_WORD_VALID,
    output logic [31:0]      O_WORD_DATA,
    input  wire logic        I_WORD_READY,
    // fault outputs
    output logic             O_GLOBAL_FAULT,
    output logic             O_EVENT_MARK
);
    // one-hot states, checked like the others
    typedef enum logic [1:0] {
        TFM_IDLE  = 2'h1,
        TFM_TRANS = 2'h2
    } tfm_state_type;

    // every flop of the block in one record
    typedef struct packed {
        tfm_state_type st;
        logic [8:0]    status;
        logic [8:0]    mask;
        logic          mask_par;
        logic [6:0]    trans;
        logic [6:0]    trans_hold;
        logic          gfault;
        logic          evmark;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [11:0]   rdata;
    } tfm_regs_type;

    // current and next state
    tfm_regs_type r, n;
    tfm_word_if   wif ();

    // helpers, rebuilt each cycle
    logic [3:0]  mem_err;
    logic [8:0]  det;
    logic [6:0]  trn_new;
    logic [8:0]  hard_word;
    logic        free;
    logic        ro_ovf;
    logic        clr_all;
    logic        own_bad;

    // true when more than one bit of the vector is set
    function automatic logic multi_hot(input logic [23:0] v);
        multi_hot = |(v & (v - 24'h000001));
    endfunction : multi_hot

    // true unless exactly one bit of the vector is set
    function automatic logic not_one_hot(input logic [23:0] v);
        not_one_hot = (v == 24'h000000) | multi_hot(v);
    endfunction : not_one_hot

    // memory word checks, one per parity-protected memory
    // order: coarse, L1, trigger, readout
    tfm_parity_check u_par (
        .i_data (I_MEM_DATA),
        .i_par  (I_MEM_PAR),
        .i_use  (I_MEM_USE),
        .o_err  (mem_err)
    );

    // two-entry buffer so a stalled reader never loses a word
    // and keeps I_WORD_READY off O_REQ_READY
    tfm_out_buffer u_buf (
        .i_clk   (I_CORE_CLK),
        .i_nrst  (I_NRST),
        .up      (wif.sink),
        .o_valid (O_WORD_VALID),
        .o_data  (O_WORD_DATA),
        .i_ready (I_WORD_READY)
    );

    // the staged word feeds the buffer
    assign wif.valid = r.wvalid;
    assign wif.data  = r.wdata;

    // the own sequencer is checked like every other state machine
    assign own_bad = (r.st != TFM_IDLE) && (r.st != TFM_TRANS);

    // hard fault detection vector
    always_comb begin
        det = '0;
        det[tfm_pkg::HB_COARSE]  = mem_err[0];
        det[tfm_pkg::HB_CHSEL]   = multi_hot(I_CHAN_SEL);
        det[tfm_pkg::HB_L1]      = mem_err[1];
        det[tfm_pkg::HB_TRIG]    = mem_err[2];
        det[tfm_pkg::HB_MATCHSM] =
            not_one_hot({16'h0000, I_MATCH_STATE});
        det[tfm_pkg::HB_ROFIFO]  = mem_err[3];
        det[tfm_pkg::HB_ROSM]    =
            not_one_hot({16'h0000, I_RO_STATE}) | own_bad;
        // an upset in the mask breaks its parity
        det[tfm_pkg::HB_CTRL]    = (^r.mask) != r.mask_par;
        det[tfm_pkg::HB_INSTR]   = (^I_INSTR) != I_INSTR_PAR;
    end

    // readout overflow only counts under the active rejection policy
    assign ro_ovf = I_ROFULL_REJECT & I_RO_FIFO_FULL &
        ((I_LEVEL1_FULL_REJECTION & I_L1_NEARLY_FULL) |
         (I_TRFULL_REJECT & I_TRIG_NEARLY_FULL) |
         (~I_LEVEL1_FULL_REJECTION & ~I_TRFULL_REJECT));

    // transient map follows the matching mode; bit 4 never set
    always_comb begin
        trn_new = '0;
        if (I_MATCH_EN) begin
            trn_new[tfm_pkg::TB_L1_OVF]  = I_L1_OVERFLOW;
            trn_new[tfm_pkg::TB_TRG_OVF] = I_TRIG_LOST;
            trn_new[tfm_pkg::TB_RO_OVF]  = ro_ovf;
            trn_new[tfm_pkg::TB_HIT]     = I_HIT_ERR_IN;
        end else begin
            trn_new[tfm_pkg::TB_L1_OVF2] =
                I_L1_OVERFLOW & I_MARK_OVR_EN;
            trn_new[tfm_pkg::TB_CHB_OVF] = I_CHBUF_REJECTED;
        end
    end

    // counter resets clear only if enabled
    assign clr_all = I_FAULT_CLEAR |
        (I_CLR_ON_CNT_RST & (I_BUNCH_CNT_RST | I_EVENT_CNT_RST));

    // hard flags go out only with marking on; software may mask them
    assign hard_word = I_EVENT_MARK_EN ? (r.status & r.mask)
                                       : 9'h000;

    // stage a word once the last has left
    assign free        = ~r.wvalid | wif.ready;
    assign O_REQ_READY = (r.st == TFM_IDLE) & free;

    // main next-state logic: registers, flags and word emission
    always_comb begin
        n = r;
        // buffer took the staged word
        if (r.wvalid & wif.ready) begin
            n.wvalid = 1'b0;
        end
        // software access to the enable field; parity kept alongside
        if (I_CSR_WR && I_CSR_ADDR == tfm_pkg::IDX_FAULT_ENABLE) begin
            n.mask     = I_CSR_WDATA[8:0];
            n.mask_par = ^I_CSR_WDATA[8:0];
        end
        // read data lags the index by a cycle
        case (I_CSR_ADDR)
            tfm_pkg::IDX_FAULT_ENABLE: n.rdata = {3'h0, r.mask};
            tfm_pkg::IDX_FAULT_STATUS: n.rdata = {3'h0, r.status};
            default:                   n.rdata = 12'h000;
        endcase
        // sticky status: a new detection wins over any clear
        if (clr_all) begin
            n.status = 9'h000;
        end
        // transient flags accumulate per event and never reach status
        n.trans = r.trans | trn_new;
        // one word staged per cycle at most
        case (r.st)
            TFM_IDLE: begin
                if (O_REQ_READY && I_FAULT_SLOT) begin
                    // flags go out with this slot
                    n.trans = 7'h00;
                    if (hard_word != 9'h000) begin
                        n.wvalid = 1'b1;
                        n.wdata  = {tfm_pkg::PKT_FAULT,
                                    I_CHIP_IDENTIFIER,
                                    15'h0000, hard_word};
                        n.status = 9'h000;
                        // transient flags wait for their own word
                        n.trans_hold = r.trans | trn_new;
                        if ((r.trans | trn_new) != 7'h00) begin
                            n.st = TFM_TRANS;
                        end
                    end else if ((r.trans | trn_new) != 7'h00) begin
                        n.wvalid = 1'b1;
                        n.wdata  = {tfm_pkg::PKT_FAULT,
                                    I_CHIP_IDENTIFIER, 17'h00000,
                                    r.trans | trn_new};
                    end
                end else if (O_REQ_READY && I_SEP_REQ) begin
                    // tag as seen at this edge
                    n.wvalid = 1'b1;
                    n.wdata  = {tfm_pkg::PKT_DEBUG, I_CHIP_IDENTIFIER,
                                tfm_pkg::SUB_SEP, 8'h00,
                                I_TRIGGER_TIME_TAG};
                end else if (O_REQ_READY && I_OCC_REQ) begin
                    // fill count as it stands now
                    n.wvalid = 1'b1;
                    n.wdata  = {tfm_pkg::PKT_DEBUG, I_CHIP_IDENTIFIER,
                                tfm_pkg::SUB_OCC, 11'h000,
                                I_RO_FIFO_FULL,
                                I_LEVEL1_FILL_COUNT};
                end
            end
            TFM_TRANS: begin
                // transient half of a split report
                if (free) begin
                    n.wvalid = 1'b1;
                    n.wdata  = {tfm_pkg::PKT_FAULT, I_CHIP_IDENTIFIER,
                                17'h00000, r.trans_hold};
                    n.st     = TFM_IDLE;
                end
            end
            default: begin
                // illegal state: back to idle
                n.st = TFM_IDLE;
            end
        endcase
        // detection last: a set beats a clear
        n.status = n.status | det;
        // fault line uses last cycle's status
        n.gfault = |(r.status & r.mask);
        n.evmark = n.gfault & I_EVENT_MARK_EN;
    end

    // state register; status and flags start clear after reset
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            r          <= '0;
            r.st       <= TFM_IDLE;
            // mask and parity agree out of reset
            r.mask     <= tfm_pkg::MASK_RESET[8:0];
            r.mask_par <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flops
    assign O_CSR_RDATA    = r.rdata;
    assign O_GLOBAL_FAULT = r.gfault;
    assign O_EVENT_MARK   = r.evmark;
endmodule : tfm_top

//--- tfm_chk.sv
// tfm_chk: concurrent checks on the fault monitor top-level ports.
// assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module tfm_chk (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_CSR_WR,
    input  wire logic [4:0]  I_CSR_ADDR,
    input  wire logic [11:0] I_CSR_WDATA,
    input  wire logic [11:0] O_CSR_RDATA,
    input  wire logic [3:0]  I_CHIP_IDENTIFIER,
    input  wire logic        I_FAULT_CLEAR,
    input  wire logic        I_CLR_ON_CNT_RST,
    input  wire logic        I_EVENT_MARK_EN,
    input  wire logic [23:0] I_CHAN_SEL,
    input  wire logic        I_FAULT_SLOT,
    input  wire logic        I_SEP_REQ,
    input  wire logic        O_REQ_READY,
    input  wire logic        O_WORD_VALID,
    input  wire logic [31:0] O_WORD_DATA,
    input  wire logic        I_WORD_READY,
    input  wire logic        O_GLOBAL_FAULT,
    input  wire logic        O_EVENT_MARK
);
    logic [8:0] mask_r;
    logic       quiet;
    // mirror of the enable mask so the fault line can be predicted
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST)
            mask_r <= 9'h000;
        else if (I_CSR_WR && I_CSR_ADDR == 5'h0C)
            mask_r <= I_CSR_WDATA[8:0];
    end
    // no clearing event and no mask change in this cycle
    assign quiet = !I_FAULT_CLEAR && !I_FAULT_SLOT && !I_CLR_ON_CNT_RST
                   && !I_CSR_WR;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    a_chsel_fault: assert property (
        $countones(I_CHAN_SEL) > 1 && mask_r[1] && quiet
        |-> ##2 O_GLOBAL_FAULT)
        else $error("fault line missed a channel select fault");
    a_mask_zero: assert property (
        mask_r == 9'h000 |=> !O_GLOBAL_FAULT)
        else $error("fault line high with all mask bits off");
    a_mark_off: assert property (
        !I_EVENT_MARK_EN |=> !O_EVENT_MARK)
        else $error("event mark high with marking off");
    a_mark_cause: assert property (
        O_EVENT_MARK |-> O_GLOBAL_FAULT)
        else $error("event mark without fault line");
    a_mask_read: assert property (
        I_CSR_ADDR == 5'h0C && !I_CSR_WR |=> O_CSR_RDATA == {3'h0, mask_r})
        else $error("enable mask read back wrong");
    a_unmapped_zero: assert property (
        I_CSR_ADDR != 5'h0C && I_CSR_ADDR != 5'h10 |=> O_CSR_RDATA == 12'h000)
        else $error("unmapped index not zero");
    a_status_sticky: assert property (
        I_CSR_ADDR == 5'h10 && quiet ##1 I_CSR_ADDR == 5'h10 && quiet
        |=> (O_CSR_RDATA & $past(O_CSR_RDATA)) == $past(O_CSR_RDATA))
        else $error("status bit dropped without a clear");
    a_word_hold: assert property (
        O_WORD_VALID && !I_WORD_READY |=> O_WORD_VALID && $stable(O_WORD_DATA))
        else $error("word changed while stalled");
    a_sep_word: assert property (
        I_SEP_REQ && O_REQ_READY && !I_FAULT_SLOT && !O_WORD_VALID |-> ##[1:2]
        O_WORD_VALID && O_WORD_DATA[31:20] == {4'h7, I_CHIP_IDENTIFIER, 4'h0})
        else $error("separator word late or malformed");
    a_fault_head: assert property (
        O_WORD_VALID && O_WORD_DATA[31:28] == 4'h6
        |-> O_WORD_DATA[27:9] == {I_CHIP_IDENTIFIER, 15'h0000})
        else $error("fault word head malformed");
    c_sep: cover property (I_SEP_REQ && O_REQ_READY);
    c_fault: cover property (O_EVENT_MARK);
    c_stall: cover property ((O_WORD_VALID && !I_WORD_READY) [*3]);
endmodule : tfm_chk
bind tfm_top tfm_chk u_chk (.I_CORE_CLK, .I_NRST, .I_CSR_WR, .I_CSR_ADDR,
    .I_CSR_WDATA, .O_CSR_RDATA, .I_CHIP_IDENTIFIER, .I_FAULT_CLEAR,
    .I_CLR_ON_CNT_RST, .I_EVENT_MARK_EN, .I_CHAN_SEL, .I_FAULT_SLOT,
    .I_SEP_REQ, .O_REQ_READY, .O_WORD_VALID, .O_WORD_DATA, .I_WORD_READY,
    .O_GLOBAL_FAULT, .O_EVENT_MARK);

//--- tfm_reader.sv
// tfm_reader: readout-side model taking 32-bit words by valid/ready.
// assumes the monitor holds valid and data until the accepting edge.
`timescale 1ns/1ps
module tfm_reader (
    input  wire logic        i_clk,
    input  wire logic [1:0]  i_mode,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_data,
    output logic             o_ready,
    output logic             o_stb,
    output logic [31:0]      o_word
);
    logic [1:0] cnt_r = 2'h0;
    // mode 0 prompt, 1 ready one cycle in four, 2 stalled
    always @(posedge i_clk) begin
        cnt_r <= cnt_r + 2'h1;
        o_stb <= i_valid && o_ready;
        o_word <= i_data;
        o_ready <= i_mode == 2'h0 || (i_mode == 2'h1 && cnt_r == 2'h0);
    end
endmodule : tfm_reader

//--- tdc_fault_monitor_bench.sv
// tdc_fault_monitor_bench: self-checking bench for tfm_top.
// assumes tfm_reader on the word path and tfm_chk bound to the dut.
`timescale 1ns/1ps
module tdc_fault_monitor_bench;
    localparam logic [3:0] ID = 4'h5;
    logic        clk, nrst, wr, fclr, clron, bcr, ecr, mark, men, movr;
    logic        rorej, l1rej, trrej, vld, rdy, stb, rq_rdy, gf, em;
    logic [4:0]  addr;
    logic [11:0] wd, rdat, tag;
    logic [3:0]  mpar, instr;
    logic [23:0] csel;
    logic [7:0]  mst, rst_s, fill;
    logic [6:0]  tr;
    logic [2:0]  rq;
    logic [1:0]  mode;
    logic [31:0] data, word;
    logic [31:0] got[$];
    int          errors, cmp_count, cyc;
    tfm_top dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CSR_WR(wr),
        .I_CSR_ADDR(addr), .I_CSR_WDATA(wd), .O_CSR_RDATA(rdat),
        .I_CHIP_IDENTIFIER(ID), .I_FAULT_CLEAR(fclr), .I_CLR_ON_CNT_RST(clron),
        .I_BUNCH_CNT_RST(bcr), .I_EVENT_CNT_RST(ecr), .I_EVENT_MARK_EN(mark),
        .I_MATCH_EN(men), .I_MARK_OVR_EN(movr), .I_ROFULL_REJECT(rorej),
        .I_LEVEL1_FULL_REJECTION(l1rej), .I_TRFULL_REJECT(trrej),
        .I_MEM_DATA(64'h0), .I_MEM_PAR(mpar), .I_MEM_USE(4'hF),
        .I_CHAN_SEL(csel), .I_MATCH_STATE(mst), .I_RO_STATE(rst_s),
        .I_INSTR(instr), .I_INSTR_PAR(1'b0), .I_L1_OVERFLOW(tr[0]),
        .I_TRIG_LOST(tr[1]), .I_RO_FIFO_FULL(tr[2]), .I_L1_NEARLY_FULL(tr[3]),
        .I_TRIG_NEARLY_FULL(tr[4]), .I_HIT_ERR_IN(tr[5]),
        .I_CHBUF_REJECTED(tr[6]), .I_FAULT_SLOT(rq[2]), .I_SEP_REQ(rq[1]),
        .I_TRIGGER_TIME_TAG(tag), .I_OCC_REQ(rq[0]), .I_LEVEL1_FILL_COUNT(fill),
        .O_REQ_READY(rq_rdy), .O_WORD_VALID(vld), .O_WORD_DATA(data),
        .I_WORD_READY(rdy), .O_GLOBAL_FAULT(gf), .O_EVENT_MARK(em));
    tfm_reader rdr (.i_clk(clk), .i_mode(mode), .i_valid(vld), .i_data(data),
        .o_ready(rdy), .o_stb(stb), .o_word(word));
    always #4 clk = ~clk;
    // collect accepted words; cut a hang short
    always @(posedge clk) begin
        if (stb)
            got.push_back(word);
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wreg(input logic [4:0] a, input logic [11:0] d);
        @(posedge clk) begin
            wr <= 1'b1;
            addr <= a;
            wd <= d;
        end
        @(posedge clk) wr <= 1'b0;
    endtask : wreg
    // read data is registered: look one edge after the index is taken
    task rreg(input logic [4:0] a, input logic [11:0] e);
        @(posedge clk) addr <= a;
        @(posedge clk);
        #1 chk("csr", {20'h0, rdat}, {20'h0, e});
    endtask : rreg
    task pulse_tr(input logic [6:0] v);
        @(posedge clk) tr <= v;
        @(posedge clk) tr <= 7'h00;
    endtask : pulse_tr
    // the request stays up until the edge at which ready is high
    task put(input logic [2:0] v);
        @(posedge clk) rq <= v;
        repeat (60) begin
            @(negedge clk);
            if (rq_rdy)
                break;
        end
        @(posedge clk) rq <= 3'h0;
    endtask : put
    task expw(input logic [31:0] e);
        repeat (80) if (got.size() == 0) @(posedge clk);
        chk("word", got.size() ? got.pop_front() : 32'hX, e);
    endtask : expw
    // one-cycle hard fault on source i, then back to legal values
    task hard(input int i);
        @(posedge clk) case (i)
            0, 2, 3, 5: mpar <= 4'h1 << (i == 0 ? 0 : i == 5 ? 3 : i - 1);
            1: csel <= 24'h000003;
            4: mst <= 8'h03;
            6: rst_s <= 8'h00;
            default: instr <= 4'h1;
        endcase
        @(posedge clk) begin
            mpar <= 4'h0;
            csel <= 24'h000001;
            mst <= 8'h01;
            rst_s <= 8'h01;
            instr <= 4'h0;
        end
    endtask : hard
    task tcase(input logic [6:0] v, input logic [6:0] e);
        pulse_tr(v);
        put(3'h4);
        expw({4'h6, ID, 17'h0, e});
    endtask : tcase
    initial begin
        {clk, nrst, wr, fclr, clron, bcr, ecr, mark, movr} = 9'h000;
        {rorej, l1rej, trrej, men} = 4'h1;
        {addr, wd, mpar, instr, tr, rq, tag, fill, mode} = 57'h0;
        {csel, mst, rst_s} = {24'h000001, 8'h01, 8'h01};
        {errors, cmp_count, cyc} = 96'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rreg(5'h0C, 12'h000);
        wreg(5'h10, 12'h0FF);
        rreg(5'h10, 12'h000);
        rreg(5'h07, 12'h000);
        wreg(5'h0C, 12'h1FF);
        rreg(5'h0C, 12'h1FF);
        // each injectable source latches its own bit until cleared
        for (int i = 0; i < 9; i++) begin
            if (i == 7)
                continue;
            hard(i);
            repeat (3) @(posedge clk);
            rreg(5'h10, 12'h001 << i);
            chk("gfault", gf, 1'b1);
            rreg(5'h10, 12'h001 << i);
            @(posedge clk) fclr <= 1'b1;
            @(posedge clk) fclr <= 1'b0;
            rreg(5'h10, 12'h000);
        end
        wreg(5'h0C, 12'h1FD);
        hard(1);
        repeat (3) @(posedge clk);
        #1 chk("gfault", gf, 1'b0);
        pulse_tr(7'h00);
        @(posedge clk) bcr <= 1'b1;
        @(posedge clk) bcr <= 1'b0;
        rreg(5'h10, 12'h002);
        @(posedge clk) begin
            clron <= 1'b1;
            ecr <= 1'b1;
        end
        @(posedge clk) ecr <= 1'b0;
        rreg(5'h10, 12'h000);
        @(posedge clk) clron <= 1'b0;
        wreg(5'h0C, 12'h1FF);
        // marking off: fault slot with a hard fault latched gives no word
        hard(1);
        put(3'h4);
        repeat (10) @(posedge clk);
        chk("count", got.size(), 0);
        chk("mark", em, 1'b0);
        rreg(5'h10, 12'h002);
        @(posedge clk) mark <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("mark", em, 1'b1);
        put(3'h4);
        expw({4'h6, ID, 15'h0, 9'h002});
        rreg(5'h10, 12'h000);
        // hard and transient together: two separate words, hard first
        hard(8);
        pulse_tr(7'h02);
        put(3'h4);
        expw({4'h6, ID, 15'h0, 9'h100});
        expw({4'h6, ID, 17'h0, 7'h02});
        @(posedge clk) mark <= 1'b0;
        tcase(7'h21, 7'h09);
        @(posedge clk) rorej <= 1'b1;
        tcase(7'h04, 7'h04);
        @(posedge clk) l1rej <= 1'b1;
        tcase(7'h06, 7'h02);
        tcase(7'h0C, 7'h04);
        @(posedge clk) {l1rej, trrej} <= 2'h1;
        tcase(7'h14, 7'h04);
        @(posedge clk) begin
            {rorej, l1rej, men, movr} <= 4'h1;
        end
        tcase(7'h43, 7'h60);
        @(posedge clk) movr <= 1'b0;
        tcase(7'h41, 7'h40);
        // stalled reader: two words wait in the buffer, none is lost
        @(posedge clk) begin
            mode <= 2'h2;
            tag <= 12'hABC;
            fill <= 8'h3C;
        end
        put(3'h2);
        @(posedge clk) tr <= 7'h04;
        put(3'h1);
        @(posedge clk) begin
            tr <= 7'h00;
            tag <= 12'h123;
        end
        repeat (10) @(posedge clk);
        chk("count", got.size(), 0);
        @(posedge clk) mode <= 2'h1;
        put(3'h2);
        expw({4'h7, ID, 4'h0, 8'h00, 12'hABC});
        expw({4'h7, ID, 4'h1, 11'h000, 1'b1, 8'h3C});
        expw({4'h7, ID, 4'h0, 8'h00, 12'h123});
        print_verdict();
    end
endmodule : tdc_fault_monitor_bench
